// ---- rtl/trh_gate.sv ----
`timescale 1ns/1ps
`include "trng_defs.svh"
// Summary of operation
// RULE_01 - Total-failure test runs from generator start
// RULE_02 - After total failure no word is released
// RULE_03 - Withhold words built from post-failure bits
// RULE_04 - Online test at start and during operation
// RULE_05 - Output blocked until start-up test passes
// RULE_06 - Online test scans every raw bit
// RULE_07 - Output words are 8 or 16 bits
// RULE_08 - Tests reject sources below entropy bound
// RULE_09 - Stuck test plus continuous repetition test
// RULE_10 - Sticky alarm cleared by reset or restart
// RULE_11 - Valid only for complete approved words
module trh_gate
    import trh_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Noise source
    input  wire logic        raw_bit,
    input  wire logic        raw_valid,
    // Control
    input  wire logic        restart,
    input  wire logic        wide_sel,
    // Consumer side
    input  wire logic        word_take,
    output trh_word_t        word_out_q,
    output trh_status_t      status_q
);

    // ============================================================
    // Health tests
    trh_state_t  state_q;
    logic        last_bit_q;
    logic [7:0]  run_len_q;
    logic [9:0]  win_cnt_q;
    logic [9:0]  ones_q;
    logic [2:0]  pass_cnt_q;
    logic        stuck_hit;
    logic        win_end;
    logic        win_bad;
    logic        ok_bit;

    // True when the count of ones of a window lies outside the band.
    function automatic logic out_of_band(input logic [9:0] n);
        out_of_band = (n < `TRH_ONES_MIN) || (n > `TRH_ONES_MAX);
    endfunction

    // A run of identical bits this long means the source is dead.
    // The count is zero on the first bit of a run, hence the limit less two.
    assign stuck_hit = raw_valid && (raw_bit == last_bit_q) && // RULE_01
                       (run_len_q >= `TRH_STUCK_LIMIT - 8'h02); // RULE_09
    assign win_end   = raw_valid && (win_cnt_q == `TRH_WIN_LEN - 10'h001);
    // The bit that closes a window is judged together with that window.
    assign win_bad   = win_end &&
                       out_of_band(ones_q + {9'h000, raw_bit}); // RULE_08
    assign ok_bit    = raw_valid && !stuck_hit &&
                       (state_q == TRH_ST_RUN);

    // ============================================================
    // Run-length test
    // The last bit starts low, so a first low bit already counts as a repeat.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_bit_q <= 1'b0;
            run_len_q  <= 8'h00;
        end else if (clk_en && (raw_valid || restart)) begin
            if (restart) begin
                run_len_q <= 8'h00;
            end else if (raw_bit == last_bit_q) begin
                if (run_len_q != 8'hFF) begin
                    run_len_q <= run_len_q + 8'h01; // RULE_09
                end
            end else begin
                run_len_q <= 8'h00;
            end
            last_bit_q <= raw_bit;
        end
    end

    // ============================================================
    // Window test
    // Every raw bit enters the window count; windows are back to back.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt_q <= 10'h000;
            ones_q    <= 10'h000;
        end else if (clk_en) begin
            if (restart || win_end) begin
                win_cnt_q <= 10'h000;
                ones_q    <= 10'h000;
            end else if (raw_valid) begin
                win_cnt_q <= win_cnt_q + 10'h001; // RULE_06
                ones_q    <= ones_q + {9'h000, raw_bit};
            end
        end
    end

    // ============================================================
    // Test state machine
    // A defect is latched until restart; only a dead source moves it on.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= TRH_ST_STARTUP;
            pass_cnt_q <= 3'h0;
        end else if (clk_en) begin
            if (restart) begin
                state_q    <= TRH_ST_STARTUP;
                pass_cnt_q <= 3'h0;
            end else begin
                unique case (state_q)
                    TRH_ST_STARTUP: begin
                        if (stuck_hit) begin
                            state_q <= TRH_ST_FAILED; // RULE_01
                        end else if (win_bad) begin
                            state_q <= TRH_ST_DEFECT; // RULE_04
                        end else if (win_end) begin
                            if (pass_cnt_q ==
                                `TRH_STARTUP_WINDOWS - 3'h1) begin
                                state_q <= TRH_ST_RUN; // RULE_05
                            end
                            pass_cnt_q <= pass_cnt_q + 3'h1;
                        end
                    end
                    TRH_ST_RUN: begin
                        if (stuck_hit) begin
                            state_q <= TRH_ST_FAILED; // RULE_03
                        end else if (win_bad) begin
                            state_q <= TRH_ST_DEFECT; // RULE_04 RULE_05
                        end
                    end
                    TRH_ST_DEFECT: begin
                        if (stuck_hit) begin
                            state_q <= TRH_ST_FAILED;
                        end
                    end
                    TRH_ST_FAILED: begin
                        state_q <= TRH_ST_FAILED; // RULE_02
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Word assembly
    logic [15:0] shift_q;
    logic [4:0]  fill_q;
    logic        wide_q;
    logic [4:0]  need;
    logic        wide_now;
    logic        assembled;

    // Number of raw bits in a word of the given width.
    function automatic logic [4:0] word_len(input logic wide);
        word_len = wide ? `TRH_W16 : `TRH_W8;
    endfunction

    // The width is taken at the first bit of a word, so a new selection
    // made between two words applies to the next one.
    assign wide_now  = (fill_q == 5'h00) ? wide_sel : wide_q;
    assign need      = word_len(wide_now); // RULE_07
    assign assembled = ok_bit && (fill_q == need - 5'h01);

    // A failing bit or a leaving of RUN throws away the partial word.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 16'h0000;
            fill_q  <= 5'h00;
            wide_q  <= 1'b0;
        end else if (clk_en) begin
            if (restart || (state_q != TRH_ST_RUN) ||
                (raw_valid && !ok_bit) || win_bad) begin
                fill_q <= 5'h00; // RULE_03
                wide_q <= wide_sel;
            end else if (ok_bit) begin
                shift_q <= {shift_q[14:0], raw_bit};
                fill_q  <= assembled ? 5'h00 : fill_q + 5'h01;
                wide_q  <= wide_now; // RULE_07
            end
        end
    end

    // ============================================================
    // Output word and status
    // Any failure clears the shown word in the cycle it is detected.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            word_out_q <= '0;
        end else if (clk_en) begin
            if (restart || (state_q != TRH_ST_RUN) || stuck_hit ||
                win_bad) begin
                word_out_q <= '0; // RULE_02 RULE_05
            end else if (assembled && !win_bad) begin
                word_out_q.valid <= 1'b1; // RULE_11
                word_out_q.wide  <= wide_q;
                word_out_q.data  <= wide_q ?
                    {shift_q[14:0], raw_bit} :
                    {8'h00, shift_q[6:0], raw_bit};
            end else if (word_take) begin
                word_out_q.valid <= 1'b0; // RULE_11
            end
        end
    end

    // Fail, defect and ready follow the state one cycle late; the alarm is set at the same edge as the state. A fault in the restart
    // cycle keeps the alarm set.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
        end else if (clk_en) begin
            status_q.total_fail <= (state_q == TRH_ST_FAILED) && !restart;
            status_q.defect     <= (state_q == TRH_ST_DEFECT) && !restart;
            status_q.ready      <= (state_q == TRH_ST_RUN) && !restart;
            if (stuck_hit || win_bad) begin
                status_q.alarm <= 1'b1; // RULE_10
            end else if (restart) begin
                status_q.alarm <= 1'b0;
            end
        end
    end

endmodule

// ---- rtl/trh_pkg.sv ----
package trh_pkg;

    // ============================================================
    // Types
    typedef enum logic [3:0] {
        TRH_ST_STARTUP = 4'b0001,
        TRH_ST_RUN     = 4'b0010,
        TRH_ST_DEFECT  = 4'b0100,
        TRH_ST_FAILED  = 4'b1000
    } trh_state_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic        wide;
    } trh_word_t;

    typedef struct packed {
        logic total_fail;
        logic defect;
        logic alarm;
        logic ready;
    } trh_status_t;

endpackage

// ---- rtl/trng_defs.svh ----
`ifndef TRNG_DEFS_SVH
`define TRNG_DEFS_SVH

// ============================================================
// Health test limits and timing
`define TRH_STUCK_LIMIT      8'h20
`define TRH_WIN_LEN          10'h3FF
`define TRH_ONES_MIN         10'h1A4
`define TRH_ONES_MAX         10'h25B
`define TRH_STARTUP_WINDOWS  3'h2
`define TRH_W8               5'h08
`define TRH_W16              5'h10

`endif

// ---- tb/trh_gate_monitor.sv ----
`timescale 1ns/1ps
module trh_gate_monitor
    import trh_pkg::*;
(
    // Inputs
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        raw_bit,
    input wire logic        raw_valid,
    input wire logic        restart,
    input wire logic        wide_sel,
    input wire logic        word_take,
    // Outputs
    input wire trh_word_t   word_out_q,
    input wire trh_status_t status_q
);
    // ====
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_fail_blocks_word: assert property (
        status_q.total_fail |-> !word_out_q.valid) else $error("word on fail");
    chk_defect_blocks_word: assert property (
        status_q.defect |-> !word_out_q.valid) else $error("word on defect");
    chk_word_needs_ready: assert property (
        $rose(word_out_q.valid) |-> status_q.ready) else $error("early word");
    chk_fail_sets_alarm: assert property (
        status_q.total_fail |-> status_q.alarm) else $error("alarm missing");
    chk_alarm_stays_set: assert property (
        status_q.alarm && !restart && !$past(restart) |=> status_q.alarm)
        else $error("alarm lost");
    chk_word_holds: assert property (
        word_out_q.valid && !word_take && !raw_valid && !restart
        |=> word_out_q.valid && $stable(word_out_q.data))
        else $error("word not held");
    chk_take_clears: assert property (
        word_out_q.valid && word_take && clk_en && !raw_valid
        |=> !word_out_q.valid) else $error("take ignored");
    chk_narrow_upper_zero: assert property (
        word_out_q.valid && !word_out_q.wide
        |-> word_out_q.data[15:8] == 8'h00)
        else $error("narrow upper set");
    cover property ($rose(word_out_q.valid) && word_out_q.wide);
    cover property ($rose(word_out_q.valid) && !word_out_q.wide);
    cover property ($rose(status_q.total_fail));
    cover property ($rose(status_q.defect));
endmodule

bind trh_gate trh_gate_monitor mon_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .raw_bit(raw_bit), .raw_valid(raw_valid),
    .restart(restart), .wide_sel(wide_sel), .word_take(word_take),
    .word_out_q(word_out_q), .status_q(status_q));

// ---- tb/trh_gate_tb.sv ----
`timescale 1ns/1ps
module trh_gate_tb;
    import trh_pkg::*;
    logic        clk_sys = 0, rst_n = 0, clk_en = 1, raw_bit = 0;
    logic        raw_valid = 0, restart = 0, wide_sel = 0, word_take = 0;
    trh_word_t   wo;
    trh_status_t st;
    int          miscompares = 0, cmp_count = 0;
    always #50 clk_sys = ~clk_sys;
    trh_gate dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .raw_bit(raw_bit), .raw_valid(raw_valid), .restart(restart),
        .wide_sel(wide_sel), .word_take(word_take), .word_out_q(wo),
        .status_q(st));
    task chk(string n, logic [17:0] s, logic [17:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Pattern 0 alternates, 1 is stuck high, 2 is three ones then a zero.
    task bits(int n, int pat, bit q);
        for (int i = 0; i < n; i++) begin
            raw_bit = pat == 0 ? i[0] : pat == 1 ? 1'b1 : (i % 4 != 3);
            raw_valid = 1;
            @(negedge clk_sys);
            if (q) chk("blocked", wo.valid, 0);
        end
        raw_valid = 0;
        repeat (3) @(negedge clk_sys);
    endtask
    task t_start;
        bits(2046, 0, 1);
        chk("ready", st, 4'h1);
    endtask
    task t_word(logic w, logic [15:0] v);
        wide_sel = w;
        for (int i = (w ? 15 : 7); i >= 0; i--) begin
            raw_bit = v[i];
            raw_valid = 1;
            @(negedge clk_sys);
        end
        raw_valid = 0;
        for (int k = 0; k < 3 && wo.valid !== 1'b1; k++) @(negedge clk_sys);
        chk("word", wo, {1'b1, v, w});
        clk_en = 0;
        word_take = 1;
        repeat (2) @(negedge clk_sys);
        chk("frozen", wo, {1'b1, v, w});
        clk_en = 1;
        @(negedge clk_sys);
        word_take = 0;
        @(negedge clk_sys);
        chk("taken", wo.valid, 0);
    endtask
    task t_rearm;
        restart = 1;
        @(negedge clk_sys);
        restart = 0;
        repeat (2) @(negedge clk_sys);
        chk("restart", st, 4'h0);
    endtask
    task t_stuck;
        bits(40, 1, 0);
        chk("fail", st, 4'hA);
        bits(24, 0, 1);
        t_rearm;
    endtask
    task t_defect;
        bits(2100, 2, 0);
        chk("defect", st[2:1], 2'h3);
        bits(24, 0, 1);
        t_rearm;
    endtask
    task stop_test;
        $display("checks %0d errors %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1;
        t_start;
        t_word(0, 16'h00A5);
        t_word(1, 16'h5AC3);
        t_stuck;
        t_start;
        t_word(0, 16'h003C);
        t_defect;
        stop_test;
    end
    initial begin
        #2000000;
        miscompares++;
        stop_test;
    end
endmodule
